// [logic/sap_pkg.sv]
/*
 * Constants, types and helper functions shared by the serial audio port.
 * It assumes a 32-bit classic Wishbone slave, a 25 MHz core clock and a
 * link clock that is slow enough to be sampled as an ordinary input.
 */
package sap_pkg;
    localparam int ADDR_W = 8;
    localparam int LANES = 2;
    localparam int CH_PER_PORT = 4;
    localparam int MAX_I2S_CH = 32;
    localparam int DIV_W = 16;
    localparam int FLEN_W = 10;
    localparam int ST_W = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CLK = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COMP = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_TX0 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_TX1 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RX0 = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_RX1 = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_IEN = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_ICLR = 8'h24;

    // field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_LSB = 4;
    localparam int CTRL_WLEN = 5;
    localparam int CTRL_CLKINT = 10;
    localparam int CTRL_FSINT = 11;
    localparam int CTRL_LTX = 12;
    localparam int CTRL_SLOTS = 14;
    localparam int CLK_DIV = 0;
    localparam int CLK_FLEN = 16;
    localparam int ST_FSERR = 0;
    localparam int ST_RX = 1;
    localparam int ST_TX = 3;
    localparam int STAT_BUSY = 8;
    localparam int STAT_FS = 9;

    // reset values
    localparam logic [DIV_W-1:0] DIV_RST = 16'h0003;
    localparam logic [FLEN_W-1:0] FLEN_RST = 10'h03f;

    // word length limits
    localparam logic [5:0] MIN_LEN_GEN = 6'h03;
    localparam logic [5:0] MIN_LEN_PAIR = 6'h08;

    // companding constants
    localparam logic [15:0] MU_BIAS = 16'h0084;
    localparam logic [15:0] MU_CLIP = 16'h7f7b;
    localparam logic [15:0] A_CLIP = 16'h0fff;
    localparam logic [7:0] A_XOR = 8'h55;

    typedef enum logic [2:0] {MODE_STD, MODE_TDM, MODE_I2S, MODE_PI2S, MODE_LJ} mode_t;
    typedef enum logic [1:0] {IDLE, ARMED, SHIFT} state_t;

    // unused codes fall back to the standard mode
    function automatic mode_t to_mode(input logic [2:0] v);
        to_mode = (v > 3'h4) ? MODE_STD : mode_t'(v);
    endfunction

    // frame sync marks both halves of a frame
    function automatic logic is_half(input mode_t m);
        is_half = (m == MODE_I2S) || (m == MODE_PI2S) || (m == MODE_LJ);
    endfunction

    // every mode but the left-justified pair has a one-bit data delay
    function automatic logic has_delay(input mode_t m);
        has_delay = (m != MODE_LJ);
    endfunction

    function automatic logic [5:0] eff_len(input mode_t m, input logic [4:0] f);
        logic [5:0] l;
        logic [5:0] lo;
        l = {1'b0, f} + 6'h01;
        lo = (m == MODE_I2S || m == MODE_LJ) ? MIN_LEN_PAIR : MIN_LEN_GEN;
        eff_len = (l < lo) ? lo : l;
    endfunction

    function automatic logic [31:0] rev32(input logic [31:0] v);
        for (int i = 0; i < 32; i++) begin
            rev32[i] = v[31-i];
        end
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            wmerge[8*i +: 8] = sel[i] ? n[8*i +: 8] : o[8*i +: 8];
        end
    endfunction
endpackage

// [logic/sap_compander.sv]
/*
 * Combinational G.711 compander for one data lane: 16-bit linear to
 * 8-bit code for sending, 8-bit code to 16-bit linear for receiving.
 * It assumes the caller picks the law per channel.
 */
`timescale 1ns/1ps
module sap_compander (
    input wire logic alaw_i,
    input wire logic [15:0] lin_i,
    input wire logic [7:0] code_i,
    output logic [7:0] code_o,
    output logic [15:0] lin_o
);
    import sap_pkg::*;

    function automatic logic [3:0] top_bit(input logic [15:0] v);
        top_bit = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                top_bit = 4'(i);
            end
        end
    endfunction

    logic neg;
    logic [15:0] mag, mu_m, a_m, mu_t, a_t;
    logic [3:0] mu_s, a_s, a_man;
    logic [7:0] cm, ca;

    // encode: mu-law searches the biased magnitude, A-law the 13-bit one
    always_comb begin
        neg = lin_i[15];
        mag = neg ? 16'(~lin_i + 16'h0001) : lin_i;
        mu_m = ((mag > MU_CLIP) ? MU_CLIP : mag) + MU_BIAS;
        mu_s = top_bit(mu_m) - 4'h7;
        a_m = mag >> 3;
        a_m = (a_m > A_CLIP) ? A_CLIP : a_m; // only -32768 overflows
        if (a_m < 16'h0020) begin
            a_s = 4'h0;
            a_man = a_m[4:1];
        end else begin
            a_s = top_bit(a_m) - 4'h4;
            a_man = 4'(a_m >> a_s);
        end
        code_o = alaw_i ? ({~neg, a_s[2:0], a_man} ^ A_XOR)
                        : ~{neg, mu_s[2:0], 4'(mu_m >> (mu_s + 4'h3))};
    end

    // decode back to a 16-bit two's-complement sample
    always_comb begin
        cm = ~code_i;
        ca = code_i ^ A_XOR;
        mu_t = 16'(({9'h000, cm[3:0], 3'h0} + MU_BIAS) << cm[6:4]) - MU_BIAS;
        a_t = {8'h00, ca[3:0], 4'h8};
        if (ca[6:4] != 3'h0) begin
            a_t = 16'((a_t + 16'h0100) << (ca[6:4] - 3'h1));
        end
        if (alaw_i) begin
            lin_o = ca[7] ? a_t : 16'(-a_t);
        end else begin
            lin_o = cm[7] ? 16'(-mu_t) : mu_t;
        end
    end
endmodule // sap_compander

// [logic/sap_link_timing.sv]
/*
 * Bit clock and frame sync for one port: makes them from the core clock
 * when set to internal (the frame sync only while the bit clock is internal too), or samples the partner's pins when external.
 * It assumes the bit clock runs well below a quarter of the core clock.
 */
`timescale 1ns/1ps
module sap_link_timing #(
    parameter int DIV_W = sap_pkg::DIV_W,
    parameter int FLEN_W = sap_pkg::FLEN_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic clk_int_i,
    input wire logic fs_int_i,
    input wire sap_pkg::mode_t mode_i,
    input wire logic [DIV_W-1:0] div_i,
    input wire logic [FLEN_W-1:0] flen_i,
    input wire logic sclk_i,
    input wire logic fs_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic fs_o,
    output logic fs_oe_o,
    output logic rise_o,
    output logic fall_o,
    output logic fs_lvl_o
);
    import sap_pkg::*;

    logic [DIV_W-1:0] dcnt_q;
    logic [FLEN_W-1:0] fcnt_q, fnx, half;
    logic sclk_q, fsg_q, prev_q, tick, sel_clk;
    logic [1:0] ext1_q, ext2_q, int1_q, int2_q;

    function automatic logic fs_gen(input mode_t m, input logic [FLEN_W-1:0] c,
                                    input logic [FLEN_W-1:0] last, input logic [FLEN_W-1:0] h);
        logic [FLEN_W-1:0] n;
        n = (c == last) ? '0 : c + 1'b1;
        if (!is_half(m)) begin
            fs_gen = (c == last); // pulse one bit ahead of the first word
        end else if (has_delay(m)) begin
            fs_gen = (n >= h); // low half leads, one bit early
        end else begin
            fs_gen = (c < h); // high half leads, no delay
        end
    endfunction

    assign tick = en_i && clk_int_i && (dcnt_q == div_i);
    assign fnx = (fcnt_q == flen_i) ? '0 : fcnt_q + 1'b1;
    assign half = FLEN_W'(({1'b0, flen_i} + 1'b1) >> 1);

    // internal bit clock divider
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i || !clk_int_i) begin
            dcnt_q <= '0;
            sclk_q <= 1'b0;
        end else if (tick) begin
            dcnt_q <= '0;
            sclk_q <= ~sclk_q;
        end else begin
            dcnt_q <= dcnt_q + 1'b1;
        end
    end

    // internal frame sync moves on the falling bit clock edge
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            fcnt_q <= '0;
            fsg_q <= 1'b0;
        end else if (tick && sclk_q) begin
            fcnt_q <= fnx;
            fsg_q <= fs_gen(mode_i, fnx, flen_i, half);
        end
    end

    // pins and own outputs take the same two-flop path so data lines up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext1_q <= 2'h0;
            ext2_q <= 2'h0;
            int1_q <= 2'h0;
            int2_q <= 2'h0;
            prev_q <= 1'b0;
        end else begin
            ext1_q <= {sclk_i, fs_i};
            ext2_q <= ext1_q;
            int1_q <= {sclk_q, fsg_q};
            int2_q <= int1_q;
            prev_q <= sel_clk;
        end
    end

    assign sel_clk = clk_int_i ? int2_q[1] : ext2_q[1];
    assign fs_lvl_o = fs_int_i ? int2_q[0] : ext2_q[0];
    assign rise_o = en_i && sel_clk && !prev_q;
    assign fall_o = en_i && !sel_clk && prev_q;
    assign sclk_o = sclk_q;
    assign sclk_oe_o = en_i && clk_int_i;
    assign fs_o = fsg_q;
    assign fs_oe_o = en_i && fs_int_i;
endmodule // sap_link_timing

// [logic/serial_audio_port.sv]
/*
 * One serial audio port: two data lanes, five framing modes, companding,
 * early frame-sync detection and a classic Wishbone register slave.
 * It assumes a 32-bit Wishbone master on clk_i and partners on the pins.
 */
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module serial_audio_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sap_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    input wire logic fs_i,
    output logic fs_o,
    output logic fs_oe_o,
    input wire logic [sap_pkg::LANES-1:0] data_i,
    output logic [sap_pkg::LANES-1:0] data_o,
    output logic [sap_pkg::LANES-1:0] data_oe_o,
    input wire logic err_chain_i,
    output logic irq_o,
    output logic err_irq_o
);
    import sap_pkg::*;

    logic en_q, lsb_q, clkint_q, fsint_q, ack_q, fsp_q, ws_q;
    mode_t mode_q;
    state_t st_q, st_d;
    logic [4:0] wlen_q;
    logic [LANES-1:0] ltx_q, shift_q, d1_q, d2_q;
    logic [3:0] slots_q, slot_q, slot_d;
    logic [DIV_W-1:0] div_q;
    logic [FLEN_W-1:0] flen_q;
    logic [7:0] comp_q;
    logic [ST_W-1:0] stat_q, ien_q, st_set, st_clr;
    logic [5:0] bit_q, bit_d, len;
    logic [31:0] tx_q [LANES];
    logic [31:0] rx_q [LANES];
    logic [31:0] txsh_q [LANES];
    logic [31:0] rxsh_q [LANES];
    logic [31:0] rx_word [LANES];
    logic [31:0] tx_word [LANES];
    logic [7:0] code [LANES];
    logic [15:0] lin [LANES];
    logic [LANES-1:0] law_on, law_a;
    logic [31:0] ctrl_rd, clk_rd, rdata, nw, cw;
    logic rise, fall, fs_lvl, start, take, done, early, last_slot, half, dly, acc, wr, tx_seg;

    // the mode picks framing, delay and the lower word-length bound
    assign half = is_half(mode_q);
    assign dly = has_delay(mode_q);
    assign len = eff_len(mode_q, wlen_q);
    // multichannel and packed I2S run several slots per frame-sync edge
    assign last_slot = (mode_q == MODE_TDM || mode_q == MODE_PI2S) ? (slot_q == slots_q) : 1'b1;
    // pair modes start a word on either frame-sync edge
    assign start = rise && (half ? (fs_lvl != fsp_q) : (fs_lvl && !fsp_q));

    sap_link_timing #(
        .DIV_W(DIV_W),
        .FLEN_W(FLEN_W)
    ) u_link (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(en_q),
        .clk_int_i(clkint_q),
        .fs_int_i(fsint_q),
        .mode_i(mode_q),
        .div_i(div_q),
        .flen_i(flen_q),
        .sclk_i(sclk_i),
        .fs_i(fs_i),
        .sclk_o(sclk_o),
        .sclk_oe_o(sclk_oe_o),
        .fs_o(fs_o),
        .fs_oe_o(fs_oe_o),
        .rise_o(rise),
        .fall_o(fall),
        .fs_lvl_o(fs_lvl)
    );

    // data pins pass two flops, matching the bit clock path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            d1_q <= '0;
            d2_q <= '0;
        end else begin
            d1_q <= data_i;
            d2_q <= d1_q;
        end
    end

    // word sequencer, one step per sampling edge of the bit clock
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        slot_d = slot_q;
        take = 1'b0;
        done = 1'b0;
        early = 1'b0;
        if (rise) begin
            unique case (st_q)
                IDLE: begin
                    if (start) begin
                        slot_d = 4'h0;
                        if (dly) begin
                            st_d = ARMED;
                        end else begin
                            take = 1'b1;
                            bit_d = 6'h01;
                            st_d = SHIFT;
                        end
                    end
                end
                ARMED: begin
                    take = 1'b1;
                    bit_d = 6'h01;
                    st_d = SHIFT;
                    early = start;
                end
                SHIFT: begin
                    // only a delayed-mode sync on the last bit of the last slot is on time
                    if (start && !(bit_q >= len - 6'h01 && last_slot && dly)) begin
                        early = 1'b1;
                        slot_d = 4'h0;
                        if (dly) begin
                            st_d = ARMED;
                            bit_d = 6'h00;
                        end else begin
                            take = 1'b1;
                            bit_d = 6'h01;
                        end
                    end else begin
                        take = 1'b1;
                        if (bit_q >= len - 6'h01) begin
                            done = 1'b1;
                            bit_d = 6'h00;
                            if (start) begin
                                st_d = ARMED;
                                slot_d = 4'h0;
                            end else if (!last_slot) begin
                                slot_d = slot_q + 4'h1;
                            end else begin
                                st_d = IDLE;
                            end
                        end else begin
                            bit_d = bit_q + 6'h01;
                        end
                    end
                end
            endcase
        end
    end

    // sequencer state and word side (left or right, odd or even slot)
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_q) begin
            st_q <= IDLE;
            bit_q <= 6'h00;
            slot_q <= 4'h0;
            fsp_q <= 1'b0;
            ws_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            slot_q <= slot_d;
            if (rise) begin
                fsp_q <= fs_lvl;
            end
            if (take && bit_d == 6'h01) begin
                ws_q <= half ? fs_lvl : slot_d[0];
            end
        end
    end

    assign tx_seg = half ? ~ws_q : slot_d[0];

    // per lane: channel law, compander, word formatting and shifters
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [1:0] ch;
        logic [31:0] sh;
        assign ch = {1'(l), ltx_q[l] ? tx_seg : ws_q};
        assign law_on[l] = comp_q[2*ch + 1];
        assign law_a[l] = comp_q[2*ch];
        assign sh = {rxsh_q[l][30:0], d2_q[l]};

        sap_compander u_comp (
            .alaw_i(law_a[l]),
            .lin_i(tx_q[l][15:0]),
            .code_i(rx_word[l][7:0]),
            .code_o(code[l]),
            .lin_o(lin[l])
        );

        // first received bit ends up in bit 0 when least-significant first
        assign rx_word[l] = lsb_q ? (rev32(sh) >> (6'h20 - len))
                                  : (sh & ~(32'hffffffff << len));
        assign tx_word[l] = law_on[l] ? {24'h000000, code[l]} : tx_q[l];

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                rxsh_q[l] <= 32'h00000000;
                rx_q[l] <= 32'h00000000;
                txsh_q[l] <= 32'h00000000;
                shift_q[l] <= 1'b0;
            end else begin
                if (take) begin
                    rxsh_q[l] <= sh;
                end
                if (done && !ltx_q[l]) begin
                    rx_q[l] <= law_on[l] ? {{16{lin[l][15]}}, lin[l]} : rx_word[l];
                end
                // next word waits on the pin so a no-delay frame finds bit 0 ready
                if (done || early || st_q == IDLE) begin
                    txsh_q[l] <= lsb_q ? rev32(tx_word[l])
                                       : (tx_word[l] << (6'h20 - len));
                    shift_q[l] <= 1'b0;
                end else if (fall && shift_q[l]) begin
                    txsh_q[l] <= txsh_q[l] << 1;
                    shift_q[l] <= 1'b0;
                end else if (take) begin
                    shift_q[l] <= 1'b1;
                end
            end
        end
        assign data_o[l] = txsh_q[l][31];
    end

    // each lane drives its pin only when set to send; four channels per port
    assign data_oe_o = {LANES{en_q}} & ltx_q;

    // Wishbone classic: one wait state, ack for one cycle
    assign acc = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = acc && wb_we_i;
    assign nw = wmerge(ctrl_rd, wb_dat_i, wb_sel_i);
    assign cw = wmerge(clk_rd, wb_dat_i, wb_sel_i);

    assign ctrl_rd = {14'h0000, slots_q, ltx_q, fsint_q, clkint_q, wlen_q, lsb_q, mode_q, en_q};
    assign clk_rd = {6'h00, flen_q, div_q};

    // control registers steer framing, clocks and lane directions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
            mode_q <= MODE_STD;
            lsb_q <= 1'b0;
            wlen_q <= 5'h00;
            clkint_q <= 1'b0;
            fsint_q <= 1'b0;
            ltx_q <= '0;
            slots_q <= 4'h0;
            div_q <= DIV_RST;
            flen_q <= FLEN_RST;
            comp_q <= 8'h00;
        end else if (wr) begin
            if (wb_adr_i == OFF_CTRL) begin
                en_q <= nw[CTRL_EN];
                mode_q <= to_mode(nw[CTRL_MODE +: 3]);
                lsb_q <= nw[CTRL_LSB];
                wlen_q <= nw[CTRL_WLEN +: 5];
                clkint_q <= nw[CTRL_CLKINT];
                fsint_q <= nw[CTRL_FSINT];
                ltx_q <= nw[CTRL_LTX +: LANES];
                slots_q <= nw[CTRL_SLOTS +: 4];
            end
            if (wb_adr_i == OFF_CLK) begin
                div_q <= cw[CLK_DIV +: DIV_W];
                flen_q <= cw[CLK_FLEN +: FLEN_W];
            end
            if (wb_adr_i == OFF_COMP) begin
                comp_q <= wb_sel_i[0] ? wb_dat_i[7:0] : comp_q;
            end
        end
    end

    // transmit holding registers and interrupt enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_q[0] <= 32'h00000000;
            tx_q[1] <= 32'h00000000;
            ien_q <= '0;
        end else if (wr) begin
            if (wb_adr_i == OFF_TX0) begin
                tx_q[0] <= wmerge(tx_q[0], wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == OFF_TX1) begin
                tx_q[1] <= wmerge(tx_q[1], wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == OFF_IEN && wb_sel_i[0]) begin
                ien_q <= wb_dat_i[ST_W-1:0];
            end
        end
    end

    // sticky events; a set in the same cycle as its clear wins
    assign st_set = {{LANES{done}} & ltx_q, {LANES{done}} & ~ltx_q, early};
    assign st_clr = (wr && wb_adr_i == OFF_ICLR && wb_sel_i[0]) ? wb_dat_i[ST_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~st_clr) | st_set;
        end
    end

    // read mux; unmapped and write-only words read as zero
    always_comb begin
        unique case (wb_adr_i)
            OFF_CTRL: rdata = ctrl_rd;
            OFF_CLK: rdata = clk_rd;
            OFF_COMP: rdata = {24'h000000, comp_q};
            OFF_TX0: rdata = tx_q[0];
            OFF_TX1: rdata = tx_q[1];
            OFF_RX0: rdata = rx_q[0];
            OFF_RX1: rdata = rx_q[1];
            OFF_STAT: rdata = {22'h000000, fs_lvl, st_q != IDLE, 3'h0, stat_q};
            OFF_IEN: rdata = {27'h0000000, ien_q};
            default: rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ack_q <= acc;
            if (acc && !wb_we_i) begin
                wb_dat_o <= rdata;
            end
        end
    end
    assign wb_ack_o = ack_q;

    // data events on one line; frame errors shared with the other ports
    assign irq_o = |(stat_q[ST_W-1:1] & ien_q[ST_W-1:1]);
    assign err_irq_o = (stat_q[ST_FSERR] & ien_q[ST_FSERR]) | err_chain_i;
endmodule // serial_audio_port

// [verif/sap_assertions.sv]
/* port checker for serial_audio_port; assumes it is bound to the top module */
`timescale 1ns/1ps
module sap_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sclk_oe_o,
    input wire logic fs_oe_o,
    input wire logic [1:0] data_oe_o,
    input wire logic err_chain_i,
    input wire logic irq_o,
    input wire logic err_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a write being answered is the only thing that may drop a sticky flag
    wire wr_ack = wb_ack_o && wb_we_i;
    a_ack_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    a_rdata_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("read data moved");
    a_reset_quiet: assert property ($past(rst_i) |-> !irq_o && !err_irq_o && !fs_oe_o && !sclk_oe_o
        && data_oe_o == 2'h0) else $error("outputs live after reset");
    a_oe_by_write: assert property ($rose(sclk_oe_o) || $rose(fs_oe_o) || $rose(|data_oe_o) |-> wr_ack)
        else $error("pin enabled without write");
    a_chain_err: assert property (err_chain_i |-> ##[0:2] err_irq_o) else $error("chain not shared");
    a_err_sticky: assert property ($fell(err_irq_o) |-> wr_ack || $past(wr_ack) || $past(err_chain_i)
        || $past(err_chain_i, 2)) else $error("error flag lost");
    a_irq_sticky: assert property ($fell(irq_o) |-> wr_ack || $past(wr_ack)) else $error("irq lost");
    c_write: cover property (wr_ack);
    c_irq: cover property ($rose(irq_o));
    c_err: cover property ($rose(err_irq_o));
endmodule // sap_assertions
bind serial_audio_port sap_assertions u_chk (.*);

// [verif/sap_codec.sv]
/* far-side serial device: makes bit clock, frame sync and both lanes */
`timescale 1ns/1ps
module sap_codec (
    output logic sclk_o,
    output logic fs_o,
    output logic [1:0] data_o
);
    initial {sclk_o, fs_o, data_o} = 4'h0;
    // one standard frame, msb first; early names a bit that gets a second sync
    task automatic frame(input logic [7:0] w, input int early);
        #13;
        for (int k = -1; k < 8; k++) begin
            {sclk_o, fs_o} = {1'b0, k == -1 || k == early};
            data_o = k < 0 ? ~data_o : {2{w[7-k]}};
            #160 sclk_o = 1;
            #160;
        end
        {sclk_o, fs_o, data_o} = {2'b00, ~data_o}; // clock stands still, lane no longer valid
    endtask
endmodule // sap_codec

// [verif/tb_serial_audio_port.sv]
/* self-checking bench for serial_audio_port; assumes the codec model beside it */
`timescale 1ns/1ps
module tb_serial_audio_port;
    import sap_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, err_chain_i = 0;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rnd = 32'h3ee26682;
    logic wb_ack_o, sclk_i, sclk_o, sclk_oe_o, fs_i, fs_o, fs_oe_o, irq_o, err_irq_o;
    logic [1:0] data_i, data_o, data_oe_o;
    logic [31:0] exp_q[$];
    int bad_count = 0, check_count = 0;
    always #20 clk_i = ~clk_i;
    serial_audio_port DUT (.*);
    sap_codec codec (.sclk_o(sclk_i), .fs_o(fs_i), .data_o(data_i));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one classic cycle; a read notes its expected data before it starts
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        if (!we) exp_q.push_back(d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hf, d};
        n = 0;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
        if (n >= 50) bad_count++;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // take read data at the very edge where ack is sampled high
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) begin
            chk(wb_dat_o, exp_q.pop_front());
        end
    end
    // next value of the stimulus shift register
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // set control, send one random word, give the sync stages time to land
    task automatic frame_rx(input logic [31:0] ctrl, input int early);
        wb(1, OFF_CTRL, ctrl);
        rnd = lfsr(rnd);
        codec.frame(rnd[7:0], early);
        repeat (8) @(posedge clk_i);
    endtask
    initial begin
        #300000 bad_count++;
        test_done;
    end
    // main sequence: reset values, msb and lsb words, early sync, shared error
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        wb(0, OFF_CLK, {6'h0, FLEN_RST, DIV_RST});
        wb(0, 8'h40, 32'h0);
        wb(1, OFF_IEN, 32'h7);
        frame_rx(32'h0e1, 99);
        chk(irq_o, 1);
        wb(0, OFF_RX0, {24'h0, rnd[7:0]});
        wb(0, OFF_RX1, {24'h0, rnd[7:0]});
        wb(0, OFF_STAT, 32'h6);
        wb(1, OFF_ICLR, 32'h1f);
        chk(irq_o, 0);
        frame_rx(32'h0f1, 99);
        wb(0, OFF_RX0, {24'h0, rnd[0], rnd[1], rnd[2], rnd[3], rnd[4], rnd[5], rnd[6], rnd[7]});
        frame_rx(32'h0e1, 3);
        chk(err_irq_o, 1);
        wb(1, OFF_ICLR, 32'h1f);
        chk(err_irq_o, 0);
        err_chain_i <= 1;
        repeat (3) @(posedge clk_i);
        chk(err_irq_o, 1);
        // own bit clock and frame sync, both lanes sending
        wb(1, OFF_CTRL, 32'h00003c01);
        chk({sclk_oe_o, fs_oe_o, data_oe_o}, 4'hf);
        @(posedge sclk_o);
        repeat (DIV_RST + 1) @(negedge clk_i);
        chk(sclk_o, 1);
        @(negedge clk_i);
        chk(sclk_o, 0);
        test_done;
    end
endmodule // tb_serial_audio_port
